// ===== pkg/cocr_pkg.sv
// cocr_pkg: shared constants and types of the charger option registers
package cocr_pkg;

  // ----------------------------------------------------------------
  // command codes and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_PRIMARY     = 8'h12;
  localparam logic [7:0]  CMD_SECONDARY   = 8'h30;
  localparam logic [15:0] PRIMARY_RESET   = 16'hE20E;
  localparam logic [15:0] SECONDARY_RESET = 16'h0211;
  // bus address is arbitrary, not taken from any part
  localparam logic [6:0]  SMB_ADDR_RESET  = 7'h09;

  // ----------------------------------------------------------------
  // field positions in the primary register
  // ----------------------------------------------------------------
  localparam int BIT_AUTOOFF     = 12;
  localparam int BIT_SWITCH_RATE = 9;
  localparam int BIT_LEARN       = 5;
  localparam int BIT_IN_RATIO    = 4;
  localparam int BIT_BAT_RATIO   = 3;
  localparam int BIT_DROPOUT     = 2;
  localparam int BIT_INPUT_LOOP  = 1;
  localparam int BIT_CHG_BLOCK   = 0;

  // ----------------------------------------------------------------
  // serial port framing and pin sampling
  // ----------------------------------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int         CLK_HZ        = 20000000;
  localparam int         PIN_SCL       = 0;
  localparam int         PIN_SDA       = 1;
  localparam int         PIN_PACK      = 2;
  localparam int         PIN_COUNT     = 3;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_ADDR = 3'b001,
    PH_CMD  = 3'b010,
    PH_WLO  = 3'b011,
    PH_WHI  = 3'b100,
    PH_RLO  = 3'b101,
    PH_RHI  = 3'b110
  } cocr_phase_t;

endpackage : cocr_pkg

// ===== pkg/cocr_opt_if.sv
// cocr_opt_if: link between the serial front end and the register bank
`timescale 1ns/1ps
`default_nettype none
interface cocr_opt_if;
  logic        wr_stb;
  logic        wr_sec;
  logic [15:0] wr_data;
  logic [15:0] primary;
  logic [15:0] secondary;
  logic        pin_low;
  logic        pin_fall;

  modport bank (input wr_stb, wr_sec, wr_data, pin_low, pin_fall,
                output primary, secondary);
  modport ctrl (output wr_stb, wr_sec, wr_data, pin_low, pin_fall,
                input primary, secondary);
endinterface : cocr_opt_if
`default_nettype wire

// ===== hdl/cocr_option_bank.sv
// cocr_option_bank: storage of both option registers and hardware clears
`timescale 1ns/1ps
`default_nettype none
module cocr_option_bank
  import cocr_pkg::*;
(
  // clock and reset
  input  wire logic  sys_clk,
  input  wire logic  rst_b,
  // register traffic
  cocr_opt_if.bank   ob
);
  import cocr_pkg::*;

  logic [15:0] primary;
  logic [15:0] secondary;
  logic [15:0] next_primary;
  logic        wr_pri;
  logic        wr_sec;
  logic        auto_clear;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign wr_pri     = ob.wr_stb & ~ob.wr_sec;
  assign wr_sec     = ob.wr_stb & ob.wr_sec;
  // the option bit in force before the write decides the clear
  assign auto_clear = ob.pin_fall & primary[BIT_AUTOOFF];

  // hardware clears win over a host write in the same cycle
  always_comb begin
    next_primary = wr_pri ? ob.wr_data : primary;
    if (ob.pin_low) begin
      next_primary[BIT_LEARN] = 1'b0;
    end
    if (auto_clear) begin
      next_primary[BIT_INPUT_LOOP] = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      primary   <= PRIMARY_RESET;
      secondary <= SECONDARY_RESET;
    end else begin
      primary <= next_primary;
      if (wr_sec) begin
        secondary <= ob.wr_data;
      end
    end
  end

  assign ob.primary   = primary;
  assign ob.secondary = secondary;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_learn_leaves;
    ob.pin_low |=> !primary[BIT_LEARN];
  endproperty
  a_learn_leaves: assert property (p_learn_leaves)
    else $error("learn bit survived a low pack pin");

  property p_autooff;
    ob.pin_fall && primary[BIT_AUTOOFF] |=> !primary[BIT_INPUT_LOOP];
  endproperty
  a_autooff: assert property (p_autooff)
    else $error("input loop bit not cleared by pin fall");

  property p_primary_store;
    wr_pri && !ob.pin_low && !ob.pin_fall |=> primary == $past(ob.wr_data);
  endproperty
  a_primary_store: assert property (p_primary_store)
    else $error("primary write not stored");

  property p_secondary_hold;
    !wr_sec |=> secondary == $past(secondary);
  endproperty
  a_secondary_hold: assert property (p_secondary_hold)
    else $error("secondary changed without a write");

endmodule : cocr_option_bank
`default_nettype wire

// ===== hdl/cocr_option_regs.sv
// cocr_option_regs: serial register port and option control outputs
`timescale 1ns/1ps
`default_nettype none
module cocr_option_regs
  import cocr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = cocr_pkg::SMB_ADDR_RESET
)(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // serial host port, open drain data
  input  wire logic        scl_pin,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe,
  // pack sense and converter status
  input  wire logic        pack_present_cellcount_pin,
  input  wire logic        battery_below_floor,
  input  wire logic        single_cell,
  input  wire logic        charge_settings_valid,
  // option controls
  output var  logic        switch_rate_select,
  output var  logic        calibration_discharge_enable,
  output var  logic        input_monitor_ratio,
  output var  logic        battery_monitor_ratio,
  output var  logic        dropout_precharge_active,
  output var  logic        battery_switch_full_on,
  output var  logic        precharge_clamp_2a,
  output var  logic        regulate_from_floor,
  output var  logic        input_current_regulation,
  output var  logic        charge_enable,
  output var  logic [15:0] secondary_option
);
  import cocr_pkg::*;

  // ----------------------------------------------------------------
  // pin sampling: three flops, change taken when last two agree
  // ----------------------------------------------------------------
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] filt;
  logic [PIN_COUNT-1:0] filt_d;

  assign pin_raw = {pack_present_cellcount_pin, sda_in, scl_pin};

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_sync
      logic s1;
      logic s2;
      logic s3;
      logic f;
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          s1 <= 1'b1;
          s2 <= 1'b1;
          s3 <= 1'b1;
          f  <= 1'b1;
        end else begin
          s1 <= pin_raw[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            f <= s3;
          end
        end
      end
      assign filt[g] = f;
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      filt_d <= '1;
    end else begin
      filt_d <= filt;
    end
  end

  // ----------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic scl_hold;
  logic bus_start;
  logic bus_stop;

  assign scl_rise  = filt[PIN_SCL] & ~filt_d[PIN_SCL];
  assign scl_fall  = ~filt[PIN_SCL] & filt_d[PIN_SCL];
  assign scl_hold  = filt[PIN_SCL] & filt_d[PIN_SCL];
  assign bus_start = scl_hold & ~filt[PIN_SDA] & filt_d[PIN_SDA];
  assign bus_stop  = scl_hold & filt[PIN_SDA] & ~filt_d[PIN_SDA];

  // ----------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------
  cocr_opt_if ob ();

  cocr_option_bank u_bank (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .ob      (ob.bank)
  );

  assign ob.pin_low  = ~filt[PIN_PACK];
  assign ob.pin_fall = ~filt[PIN_PACK] & filt_d[PIN_PACK];

  // ----------------------------------------------------------------
  // word transfer engine
  // ----------------------------------------------------------------
  cocr_phase_t phase;
  cocr_phase_t next_phase;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  cmd;
  logic [7:0]  data_lo;
  logic        rw;
  logic        ack_phase;
  logic        host_nack;
  logic        wr_stb;
  logic        wr_sec;
  logic [15:0] wr_data;
  logic        byte_done;
  logic        rx_phase;
  logic        cmd_known;
  logic        ack_ok;
  logic [15:0] rd_word;
  logic [7:0]  tx_byte;
  logic        tx_load;

  assign byte_done = (bit_cnt == BITS_PER_BYTE);
  assign rx_phase  = (phase == PH_ADDR) | (phase == PH_CMD) |
                     (phase == PH_WLO) | (phase == PH_WHI);
  // unknown commands get no acknowledge, so no transfer follows
  assign cmd_known = (shreg == CMD_PRIMARY) | (shreg == CMD_SECONDARY);
  assign ack_ok    = (phase == PH_ADDR) ? (shreg[7:1] == DEV_ADDR) :
                     (phase == PH_CMD)  ? cmd_known : 1'b1;
  assign rd_word   = (cmd == CMD_SECONDARY) ? ob.secondary : ob.primary;
  assign tx_byte   = (next_phase == PH_RLO) ? rd_word[7:0] : rd_word[15:8];
  assign tx_load   = (next_phase == PH_RLO) | (next_phase == PH_RHI);

  // low byte first in both directions
  always_comb begin
    case (phase)
      PH_ADDR: next_phase = rw ? PH_RLO : PH_CMD;
      PH_CMD:  next_phase = PH_WLO;
      PH_WLO:  next_phase = PH_WHI;
      PH_RLO:  next_phase = host_nack ? PH_IDLE : PH_RHI;
      default: next_phase = PH_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase     <= PH_IDLE;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      cmd       <= 8'h00;
      data_lo   <= 8'h00;
      rw        <= 1'b0;
      ack_phase <= 1'b0;
      host_nack <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (bus_start) begin
      phase     <= PH_ADDR;
      bit_cnt   <= 4'h0;
      ack_phase <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (bus_stop) begin
      phase     <= PH_IDLE;
      ack_phase <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (phase != PH_IDLE && scl_rise) begin
      if (ack_phase) begin
        host_nack <= filt[PIN_SDA];
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
        if (rx_phase) begin
          shreg <= {shreg[6:0], filt[PIN_SDA]};
        end
      end
    end else if (phase != PH_IDLE && scl_fall) begin
      if (ack_phase) begin
        ack_phase <= 1'b0;
        bit_cnt   <= 4'h0;
        phase     <= next_phase;
        shreg     <= tx_byte;
        sda_oe    <= tx_load & ~tx_byte[7];
      end else if (byte_done) begin
        ack_phase <= rx_phase ? ack_ok : 1'b1;
        sda_oe    <= rx_phase & ack_ok;
        if (rx_phase && !ack_ok) begin
          phase <= PH_IDLE;
        end
        if (phase == PH_ADDR) begin
          rw <= shreg[0];
        end
        if (phase == PH_CMD) begin
          cmd <= shreg;
        end
        if (phase == PH_WLO) begin
          data_lo <= shreg;
        end
      end else if (!rx_phase) begin
        shreg  <= {shreg[6:0], 1'b0};
        sda_oe <= ~shreg[6];
      end
    end
  end

  // one-cycle strobe once the high byte of a write has arrived
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_stb  <= 1'b0;
      wr_sec  <= 1'b0;
      wr_data <= 16'h0000;
    end else begin
      wr_stb  <= scl_fall & ~ack_phase & byte_done & (phase == PH_WHI);
      wr_sec  <= (cmd == CMD_SECONDARY);
      wr_data <= {shreg, data_lo};
    end
  end

  assign ob.wr_stb  = wr_stb;
  assign ob.wr_sec  = wr_sec;
  assign ob.wr_data = wr_data;

  // ----------------------------------------------------------------
  // option controls, all registered
  // ----------------------------------------------------------------
  logic [15:0] pri;
  logic        dropout_now;

  assign pri         = ob.primary;
  assign dropout_now = pri[BIT_DROPOUT] & battery_below_floor;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_out                      <= 1'b0;
      switch_rate_select           <= PRIMARY_RESET[BIT_SWITCH_RATE];
      calibration_discharge_enable <= PRIMARY_RESET[BIT_LEARN];
      input_monitor_ratio          <= PRIMARY_RESET[BIT_IN_RATIO];
      battery_monitor_ratio        <= PRIMARY_RESET[BIT_BAT_RATIO];
      dropout_precharge_active     <= 1'b0;
      battery_switch_full_on       <= 1'b1;
      precharge_clamp_2a           <= 1'b0;
      regulate_from_floor          <= PRIMARY_RESET[BIT_DROPOUT];
      input_current_regulation     <= PRIMARY_RESET[BIT_INPUT_LOOP];
      charge_enable                <= 1'b0;
      secondary_option             <= SECONDARY_RESET;
    end else begin
      sda_out                      <= 1'b0;
      switch_rate_select           <= pri[BIT_SWITCH_RATE];
      calibration_discharge_enable <= pri[BIT_LEARN];
      input_monitor_ratio          <= pri[BIT_IN_RATIO];
      battery_monitor_ratio        <= pri[BIT_BAT_RATIO];
      dropout_precharge_active     <= dropout_now;
      battery_switch_full_on       <= ~dropout_now;
      precharge_clamp_2a           <= single_cell;
      regulate_from_floor          <= pri[BIT_DROPOUT];
      input_current_regulation     <= pri[BIT_INPUT_LOOP];
      charge_enable                <= ~pri[BIT_CHG_BLOCK] &
                                      charge_settings_valid;
      secondary_option             <= ob.secondary;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_rate_follows;
    ##1 switch_rate_select == $past(pri[BIT_SWITCH_RATE]);
  endproperty
  a_rate_follows: assert property (p_rate_follows)
    else $error("switch rate does not follow bit 9");

  property p_learn_out_drops;
    ob.pin_low ##1 ob.pin_low |=> !calibration_discharge_enable;
  endproperty
  a_learn_out_drops: assert property (p_learn_out_drops)
    else $error("learn mode still on with pack pin low");

  property p_ratios;
    ##1 {input_monitor_ratio, battery_monitor_ratio} ==
        $past({pri[BIT_IN_RATIO], pri[BIT_BAT_RATIO]});
  endproperty
  a_ratios: assert property (p_ratios)
    else $error("monitor ratios do not follow bits 4 and 3");

  property p_dropout_excl;
    dropout_precharge_active |-> !battery_switch_full_on &&
                                 regulate_from_floor;
  endproperty
  a_dropout_excl: assert property (p_dropout_excl)
    else $error("dropout precharge with switch fully on");

  property p_dropout_cause;
    pri[BIT_DROPOUT] && battery_below_floor |=> dropout_precharge_active;
  endproperty
  a_dropout_cause: assert property (p_dropout_cause)
    else $error("dropout precharge not entered below floor");

  property p_loop_out;
    ##1 input_current_regulation == $past(pri[BIT_INPUT_LOOP]);
  endproperty
  a_loop_out: assert property (p_loop_out)
    else $error("input loop output does not follow bit 1");

  property p_charge_gate;
    charge_enable |-> $past(!pri[BIT_CHG_BLOCK] && charge_settings_valid);
  endproperty
  a_charge_gate: assert property (p_charge_gate)
    else $error("charging enabled while inhibited or invalid");

  property p_write_end;
    wr_stb |-> phase == PH_WHI && $past(phase) == PH_WHI;
  endproperty
  a_write_end: assert property (p_write_end)
    else $error("write strobe outside the high data byte");

  property p_bad_cmd;
    phase == PH_CMD && scl_fall && byte_done && !ack_ok
      |=> phase == PH_IDLE && !sda_oe;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd)
    else $error("unknown command was acknowledged");

endmodule : cocr_option_regs
`default_nettype wire

// ===== tb/cocr_host_model.sv
// cocr_host_model: bus host that issues word reads and writes
`timescale 1ns/1ps
`default_nettype none
module cocr_host_model
  import cocr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = cocr_pkg::SMB_ADDR_RESET
)(
  // clock
  input  wire logic sys_clk,
  // bus pins, data is open drain with pull-up
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_low
);
  // ----------------------------------------------------------------
  // bit level, phases of 10 clocks to clear the pin filters
  // ----------------------------------------------------------------
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : tick

  // data moves only while clock is low, held 10 clocks past each fall
  task automatic bit_io(input logic drive_low, output logic seen);
    sda_low = drive_low;
    tick(10);
    scl = 1'b1;
    tick(5);
    seen = sda_line;
    tick(5);
    scl = 1'b0;
    tick(10);
  endtask : bit_io

  task automatic start_cond();
    sda_low = 1'b0;
    tick(10);
    scl = 1'b1;
    tick(10);
    sda_low = 1'b1;
    tick(10);
    scl = 1'b0;
    tick(10);
  endtask : start_cond

  task automatic stop_cond();
    sda_low = 1'b1;
    tick(10);
    scl = 1'b1;
    tick(10);
    sda_low = 1'b0;
    tick(10);
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(~b[i], s);
    end
    bit_io(1'b0, s);
    ack = ~s;
  endtask : send_byte

  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b0, s);
      b[i] = s;
    end
    bit_io(~last, s);
  endtask : recv_byte

  // ----------------------------------------------------------------
  // word transfers, low byte first
  // ----------------------------------------------------------------
  task automatic write_word(input logic [6:0] adr, input logic [7:0] cmd,
                            input logic [15:0] d, output logic [3:0] acks);
    start_cond();
    send_byte({adr, 1'b0}, acks[0]);
    send_byte(cmd, acks[1]);
    send_byte(d[7:0], acks[2]);
    send_byte(d[15:8], acks[3]);
    stop_cond();
  endtask : write_word

  task automatic read_word(input logic [7:0] cmd, output logic [15:0] d,
                           output logic ok);
    logic [2:0] a;
    start_cond();
    send_byte({DEV_ADDR, 1'b0}, a[0]);
    send_byte(cmd, a[1]);
    start_cond();
    send_byte({DEV_ADDR, 1'b1}, a[2]);
    recv_byte(1'b0, d[7:0]);
    recv_byte(1'b1, d[15:8]);
    stop_cond();
    ok = &a;
  endtask : read_word

  // low byte only; the host refuses the rest with a nack
  task automatic read_low(input logic [7:0] cmd, output logic [7:0] d);
    logic s;
    start_cond();
    send_byte({DEV_ADDR, 1'b0}, s);
    send_byte(cmd, s);
    start_cond();
    send_byte({DEV_ADDR, 1'b1}, s);
    recv_byte(1'b1, d);
    stop_cond();
  endtask : read_low
endmodule : cocr_host_model
`default_nettype wire

// ===== tb/cocr_option_regs_tb.sv
// cocr_option_regs_tb: random and corner tests of the option registers
`timescale 1ns/1ps
`default_nettype none
module cocr_option_regs_tb;
  import cocr_pkg::*;
  logic        sys_clk;
  logic        rst_b;
  logic        scl;
  logic        host_low;
  logic        pack_pin;
  logic        below;
  logic        single;
  logic        valid;
  wire  logic  sda_oe;
  wire  logic  sda_line;
  wire  logic  sda_drv;
  wire  logic [9:0]  outs;
  wire  logic [15:0] sec_out;
  logic [15:0] exp_p;
  logic [15:0] exp_s;
  logic [15:0] v;
  logic [15:0] r;
  logic [3:0]  a;
  logic        ok;
  logic [31:0] rng;
  int          mismatches;
  int          n_compared;
  int          cycles;

  // ----------------------------------------------------------------
  // clock, wiring and instances
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // pull-up: either party pulling low wins
  assign sda_line = ~(sda_oe | host_low);

  cocr_option_regs uut (
    .sys_clk                      (sys_clk),
    .rst_b                        (rst_b),
    .scl_pin                      (scl),
    .sda_in                       (sda_line),
    .sda_out                      (sda_drv),
    .sda_oe                       (sda_oe),
    .pack_present_cellcount_pin   (pack_pin),
    .battery_below_floor          (below),
    .single_cell                  (single),
    .charge_settings_valid        (valid),
    .switch_rate_select           (outs[9]),
    .calibration_discharge_enable (outs[8]),
    .input_monitor_ratio          (outs[7]),
    .battery_monitor_ratio        (outs[6]),
    .dropout_precharge_active     (outs[5]),
    .battery_switch_full_on       (outs[4]),
    .precharge_clamp_2a           (outs[3]),
    .regulate_from_floor          (outs[2]),
    .input_current_regulation     (outs[1]),
    .charge_enable                (outs[0]),
    .secondary_option             (sec_out)
  );

  cocr_host_model host (
    .sys_clk  (sys_clk),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_low  (host_low)
  );

  // ----------------------------------------------------------------
  // expectations, comparison and closing
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [9:0] exp_outs(input logic [15:0] p);
    return {p[9], p[5], p[4], p[3], p[2] & below, ~(p[2] & below),
            single, p[2], p[1], ~p[0] & valid};
  endfunction : exp_outs

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic check_outs();
    // open-drain data drive value must stay low
    check({5'h00, sda_drv, outs}, {6'h00, exp_outs(exp_p)});
    check(sec_out, exp_s);
  endtask : check_outs

  task automatic complete_run();
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // the host only counts clocks; this fails and ends the run at 80000 clocks
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 32'h0001_3880) begin
      mismatches++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    pack_pin = 1'b1;
    below = 1'b0;
    single = 1'b0;
    valid = 1'b1;
    mismatches = 0;
    n_compared = 0;
    cycles = 0;
    rng = 32'h0000_0A1A;
    exp_p = PRIMARY_RESET;
    exp_s = SECONDARY_RESET;
    repeat (16) @(posedge sys_clk);
    #2 rst_b = 1'b1;
    repeat (8) @(posedge sys_clk);
    #2;
    check_outs();
    host.read_word(CMD_PRIMARY, r, ok);
    check(r & 16'h023F, 16'h020E);
    check({15'h0000, ok}, 16'h0001);
    host.read_word(CMD_SECONDARY, r, ok);
    check(r, SECONDARY_RESET);
    check({15'h0000, ok}, 16'h0001);
    for (int k = 0; k < 12; k++) begin
      rng = xs(rng);
      v = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : rng[15:0];
      {below, single, valid} = rng[18:16];
      host.write_word(SMB_ADDR_RESET, k[1] ? CMD_SECONDARY : CMD_PRIMARY,
                      v, a);
      check({12'h000, a}, 16'h000F);
      if (k[1]) exp_s = v;
      else exp_p = v;
      host.read_word(k[1] ? CMD_SECONDARY : CMD_PRIMARY, r, ok);
      check(r, v);
      check({15'h0000, ok}, 16'h0001);
      check_outs();
    end
    // wrong device address, then an unknown command
    host.write_word(SMB_ADDR_RESET ^ 7'h01, CMD_PRIMARY, 16'h1234, a);
    check({12'h000, a}, 16'h0000);
    host.write_word(SMB_ADDR_RESET, 8'h13, 16'h1234, a);
    check({12'h000, a}, 16'h0001);
    // host refuses the high byte; the engine must free the bus for the stop
    host.read_low(CMD_PRIMARY, r[7:0]);
    check({8'h00, r[7:0]}, {8'h00, exp_p[7:0]});
    host.read_word(CMD_PRIMARY, r, ok);
    check(r, exp_p);
    // pack removal with auto-off clear and without
    for (int ao = 0; ao < 2; ao++) begin
      v = (ao == 1) ? 16'h1022 : 16'h0022;
      host.write_word(SMB_ADDR_RESET, CMD_PRIMARY, v, a);
      pack_pin = 1'b0;
      repeat (10) @(posedge sys_clk);
      #2;
      exp_p = v & ((ao == 1) ? 16'hFFDD : 16'hFFDF);
      check_outs();
      host.read_word(CMD_PRIMARY, r, ok);
      check(r, exp_p);
      host.write_word(SMB_ADDR_RESET, CMD_PRIMARY, v, a);
      exp_p = v & 16'hFFDF;
      host.read_word(CMD_PRIMARY, r, ok);
      check(r, exp_p);
      pack_pin = 1'b1;
      repeat (10) @(posedge sys_clk);
      #2;
    end
    complete_run();
  end
endmodule : cocr_option_regs_tb
`default_nettype wire
